// ### rtl/interrupt_priority_acknowledge.sv
`timescale 1ns/1ps
`include "irq_consts.svh"
// Operation
// R1: all priority flag bytes reset to ones, every source at lower level.
// R2: two low priority bytes also writable together as one 16-bit word.
// R3: software keeps watchdog priority flag at one in watchdog mode.
// R4: software writes ones into the two unused top bits of byte three.
// R5: rising and falling enable pair per pin selects off, fall, rise, both.
// R6: edge enable registers at consecutive addresses, reset zero, top bits zero.
// R7: status word resets to value with only bit one set.
// R8: enable bit changed by enable, disable instructions, bit ops, byte writes.
// R9: status word pushed by push, restored by returns and pop.
// R10: non-maskable request ignores enable and priority and outranks everything.
// R11: non-maskable accept pushes status then pc, clears enable and priority.
// R12: non-maskable during handler waits for return plus one instruction.
// R13: repeated non-maskable requests during a handler collapse into one.
// R14: maskable eligible when flagged and unmasked, taken only while enabled.
// R15: low-priority requests refused and kept pending during high-priority service.
// R16: high-level request reaches servicing within seven to thirty-two clocks.
// R17: low-level request takes one clock longer at both bounds.
// R18: requests before a divide may wait longer, until it completes.
// R19: higher programmed level wins, then fixed default order among equals.
// R20: held-off requests stay pending and are taken once conditions allow.
// R21: maskable accept pushes status, pc, clears enable, copies priority bit.
// R22: in-service bit zero in high-priority service, else one.
// R23: priority flag zero means higher level, one lower level.
// R24: request flag cleared on acceptance and by reset.
// R25: mask flag zero allows servicing, one blocks; masks reset to one.
// R26: enable at status bit seven, in-service priority at bit one.
module interrupt_priority_acknowledge #(
  parameter int PINS = `EDGE_PINS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] sfr_addr,
  input wire logic [15:0] sfr_wdata,
  input wire logic sfr_wr_byte,
  input wire logic sfr_wr_word,
  input wire logic sfr_bit_wr,
  input wire logic [2:0] sfr_bit_pos,
  input wire logic sfr_rd,
  output logic [15:0] sfr_rdata,
  input wire logic [PINS-1:0] external_irq_pin,
  output logic [PINS-1:0] ext_edge_event,
  input wire logic [21:0] request_flag,
  input wire logic [21:0] mask_flag,
  output logic [21:0] request_clear,
  input wire logic nmi_request,
  input wire logic instr_end,
  input wire logic instr_hold,
  input wire logic enable_irq_instr,
  input wire logic disable_irq_instr,
  input wire logic psw_write,
  input wire logic [7:0] psw_wdata,
  input wire logic psw_restore,
  input wire logic [7:0] psw_restore_data,
  input wire logic irq_return_instr,
  output logic [7:0] status_word,
  output logic ack_busy,
  output logic push_psw,
  output logic push_pc,
  output logic vector_load,
  output logic [7:0] stack_data,
  output logic vector_nmi,
  output logic [4:0] vector_index
);

  localparam int N = 22;
  localparam int IDX_W = 5;

  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_s_n;
  logic [7:0] prio_low0_reg;
  logic [7:0] prio_high0_reg;
  logic [7:0] prio_low1_reg;
  logic [7:0] rise_en_reg;
  logic [7:0] fall_en_reg;
  logic [7:0] psw_reg;
  logic [15:0] rdata_reg;
  logic nmi_pend_reg;
  logic in_nmi_reg;
  logic kind_nmi_reg;
  logic level_reg;
  logic [IDX_W-1:0] index_reg;
  logic [7:0] saved_psw_reg;
  logic [N-1:0] clear_reg;
  irq_pkg::ack_state_t state_reg;
  irq_pkg::ack_state_t state_next;
  logic [N-1:0] level_vec;
  logic [N-1:0] pend_vec;
  logic accept_ok;
  logic take_nmi;
  logic take_mask;
  logic ie;
  logic in_service_priority;

  irq_sel_if #(.N(N), .IDX_W(IDX_W)) sel_bus ();

  // reset release through two flip-flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_s_n = rst_sync_reg;

  // byte or single-bit update of one register
  function automatic logic [7:0] sfr_update(
    input logic [7:0] cur,
    input logic hit,
    input logic wr_byte,
    input logic wr_bit,
    input logic [2:0] pos,
    input logic [7:0] data
  );
    logic [7:0] res;
    res = cur;
    if (hit && wr_byte) begin
      res = data;
    end else if (hit && wr_bit) begin
      res[pos] = data[0];
    end
    return res;
  endfunction

  // priority flag bytes, word write covers the low pair
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      prio_low0_reg <= `PRIO_RESET; // R1
      prio_high0_reg <= `PRIO_RESET; // R1
      prio_low1_reg <= `PRIO_RESET; // R1
    end else if (sfr_wr_word && sfr_addr == `ADDR_PRIO_LOW0) begin
      prio_low0_reg <= sfr_wdata[7:0]; // R2
      prio_high0_reg <= sfr_wdata[15:8]; // R2
    end else begin
      prio_low0_reg <= sfr_update(prio_low0_reg,
        sfr_addr == `ADDR_PRIO_LOW0, sfr_wr_byte, sfr_bit_wr,
        sfr_bit_pos, sfr_wdata[7:0]);
      prio_high0_reg <= sfr_update(prio_high0_reg,
        sfr_addr == `ADDR_PRIO_HIGH0, sfr_wr_byte, sfr_bit_wr,
        sfr_bit_pos, sfr_wdata[7:0]);
      prio_low1_reg <= sfr_update(prio_low1_reg,
        sfr_addr == `ADDR_PRIO_LOW1, sfr_wr_byte, sfr_bit_wr,
        sfr_bit_pos, sfr_wdata[7:0]);
    end
  end

  // edge enables, upper bits forced to zero
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      rise_en_reg <= `EDGE_RESET; // R6
      fall_en_reg <= `EDGE_RESET; // R6
    end else begin
      rise_en_reg <= sfr_update(rise_en_reg,
        sfr_addr == `ADDR_RISE_EN, sfr_wr_byte, sfr_bit_wr,
        sfr_bit_pos, sfr_wdata[7:0]) & 8'h3f; // R6
      fall_en_reg <= sfr_update(fall_en_reg,
        sfr_addr == `ADDR_FALL_EN, sfr_wr_byte, sfr_bit_wr,
        sfr_bit_pos, sfr_wdata[7:0]) & 8'h3f; // R6
    end
  end

  // registered read data, unmapped addresses read zero
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      rdata_reg <= 16'h0000;
    end else if (sfr_rd) begin
      case (sfr_addr)
        `ADDR_PRIO_LOW0: rdata_reg <= {prio_high0_reg, prio_low0_reg};
        `ADDR_PRIO_HIGH0: rdata_reg <= {8'h00, prio_high0_reg};
        `ADDR_PRIO_LOW1: rdata_reg <= {8'h00, prio_low1_reg};
        `ADDR_RISE_EN: rdata_reg <= {8'h00, rise_en_reg};
        `ADDR_FALL_EN: rdata_reg <= {8'h00, fall_en_reg};
        default: rdata_reg <= 16'h0000;
      endcase
    end
  end
  assign sfr_rdata = rdata_reg;

  // external pin edge detection
  edge_detect #(.PINS(PINS)) u_edges (
    .clk(clk),
    .rst_n(rst_s_n),
    .pin_in(external_irq_pin),
    .rise_en(rise_en_reg[PINS-1:0]),
    .fall_en(fall_en_reg[PINS-1:0]),
    .edge_pulse(ext_edge_event) // R5
  );

  // status word fields
  assign ie = psw_reg[`PSW_IE_BIT]; // R26
  assign in_service_priority = psw_reg[`PSW_ISP_BIT]; // R26

  // eligible sources and allowed levels
  assign level_vec = {prio_low1_reg[5:0], prio_high0_reg, prio_low0_reg};
  assign pend_vec = request_flag & ~mask_flag; // R14 R25
  assign sel_bus.eligible = pend_vec & (in_service_priority ? {N{1'b1}} : ~level_vec); // R15
  assign sel_bus.level = level_vec; // R23

  priority_select #(.N(N), .IDX_W(IDX_W)) u_select (
    .sel(sel_bus) // R19
  );

  // acceptance point: end of a non-return instruction that does not hold requests, sequencer idle
  assign accept_ok = instr_end && !instr_hold && !irq_return_instr &&
                     state_reg == irq_pkg::ST_IDLE; // R12 R18
  assign take_nmi = accept_ok && nmi_pend_reg && !in_nmi_reg; // R10
  assign take_mask = accept_ok && !take_nmi && !in_nmi_reg && ie &&
                     sel_bus.found; // R14 R20

  // single pending non-maskable request, set wins over clear
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      nmi_pend_reg <= 1'b0;
    end else if (nmi_request) begin
      nmi_pend_reg <= 1'b1; // R13
    end else if (take_nmi) begin
      nmi_pend_reg <= 1'b0;
    end
  end

  // non-maskable handler in progress until its return
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      in_nmi_reg <= 1'b0;
    end else if (take_nmi) begin
      in_nmi_reg <= 1'b1;
    end else if (irq_return_instr) begin
      in_nmi_reg <= 1'b0; // R12
    end
  end

  // capture of the accepted request
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      kind_nmi_reg <= 1'b0;
      level_reg <= 1'b1;
      index_reg <= '0;
      saved_psw_reg <= `PSW_RESET;
    end else if (take_nmi || take_mask) begin
      kind_nmi_reg <= take_nmi;
      level_reg <= take_nmi ? 1'b0 : sel_bus.pick_level;
      index_reg <= sel_bus.pick;
      saved_psw_reg <= psw_reg;
    end
  end

  // one-cycle clear pulse for the accepted request flag
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      clear_reg <= '0;
    end else if (take_mask) begin
      clear_reg <= N'(1) << sel_bus.pick; // R24
    end else begin
      clear_reg <= '0;
    end
  end
  assign request_clear = clear_reg;

  // acknowledge sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      irq_pkg::ST_IDLE: begin
        if (take_nmi) begin
          state_next = irq_pkg::ST_PUSH_PSW;
        end else if (take_mask) begin
          state_next = sel_bus.pick_level ? irq_pkg::ST_LOW_WAIT
                                          : irq_pkg::ST_PUSH_PSW; // R16 R17
        end
      end
      irq_pkg::ST_LOW_WAIT: state_next = irq_pkg::ST_PUSH_PSW; // R17
      irq_pkg::ST_PUSH_PSW: state_next = irq_pkg::ST_PUSH_PC;
      irq_pkg::ST_PUSH_PC: state_next = irq_pkg::ST_VECTOR;
      irq_pkg::ST_VECTOR: state_next = irq_pkg::ST_IDLE;
      default: state_next = irq_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      state_reg <= irq_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // status word: acknowledge, restore, write, enable/disable
  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      psw_reg <= `PSW_RESET; // R7
    end else if (state_reg == irq_pkg::ST_PUSH_PC) begin
      psw_reg[`PSW_IE_BIT] <= 1'b0; // R11 R21
      psw_reg[`PSW_ISP_BIT] <= kind_nmi_reg ? 1'b0 : level_reg; // R21 R22
    end else if (psw_restore) begin
      psw_reg <= psw_restore_data; // R9
    end else if (psw_write) begin
      psw_reg <= psw_wdata; // R8
    end else if (enable_irq_instr) begin
      psw_reg[`PSW_IE_BIT] <= 1'b1; // R8
    end else if (disable_irq_instr) begin
      psw_reg[`PSW_IE_BIT] <= 1'b0; // R8
    end
  end
  assign status_word = psw_reg; // R9

  // stack data and vector selection from flip-flops
  assign stack_data = saved_psw_reg; // R11
  assign vector_nmi = kind_nmi_reg;
  assign vector_index = index_reg;

  // sequencer strobes
  assign ack_busy = state_reg != irq_pkg::ST_IDLE;
  assign push_psw = state_reg == irq_pkg::ST_PUSH_PSW;
  assign push_pc = state_reg == irq_pkg::ST_PUSH_PC;
  assign vector_load = state_reg == irq_pkg::ST_VECTOR;

  // checks on the acknowledge behaviour and the edge enable read data
  sequence s_save;
    push_psw ##1 push_pc ##1 vector_load;
  endsequence

  sequence s_low_save;
    state_reg == irq_pkg::ST_LOW_WAIT ##1 s_save;
  endsequence

  a_nmi_outranks: assert property (@(posedge clk) // R10
    disable iff (!rst_s_n) accept_ok && nmi_pend_reg && !in_nmi_reg |->
    !take_mask ##1 vector_nmi) else $error("nmi not taken first");

  a_high_save_order: assert property (@(posedge clk) // R16
    disable iff (!rst_s_n) (take_nmi || (take_mask && !sel_bus.pick_level))
    |=> s_save) else $error("high level save order wrong");

  a_low_extra_clock: assert property (@(posedge clk) // R17
    disable iff (!rst_s_n) take_mask && sel_bus.pick_level |=> s_low_save)
    else $error("low level save missing wait");

  a_nmi_psw_clear: assert property (@(posedge clk) // R11
    disable iff (!rst_s_n) push_pc && vector_nmi |=> !ie && !in_service_priority)
    else $error("nmi did not clear enable and priority");

  a_isp_copy: assert property (@(posedge clk) // R21
    disable iff (!rst_s_n) take_mask |->
    ##3 (push_pc ##1 (!ie && in_service_priority == $past(level_reg))) or
    ##2 (push_pc ##1 (!ie && in_service_priority == $past(level_reg))))
    else $error("in-service bit not copied");

  a_enable_gates: assert property (@(posedge clk) // R14
    disable iff (!rst_s_n) take_mask |-> ie && (|(request_flag & ~mask_flag)))
    else $error("maskable taken while disabled");

  a_isp_refuses_low: assert property (@(posedge clk) // R15
    disable iff (!rst_s_n) take_mask && !in_service_priority |-> !sel_bus.pick_level)
    else $error("low request taken in high service");

  a_level_first: assert property (@(posedge clk) // R19
    disable iff (!rst_s_n) take_mask && in_service_priority && (|(pend_vec & ~level_vec))
    |-> !sel_bus.pick_level) else $error("lower level chosen over higher");

  a_clear_on_take: assert property (@(posedge clk) // R24
    disable iff (!rst_s_n) take_mask |=>
    request_clear == (N'(1) << $past(sel_bus.pick)) ##1 request_clear == '0)
    else $error("request flag clear wrong");

  a_return_defers: assert property (@(posedge clk) // R12
    disable iff (!rst_s_n) irq_return_instr |-> !take_nmi && !take_mask ##1
    !in_nmi_reg) else $error("accepted at return boundary");

  a_nmi_collapse: assert property (@(posedge clk) // R13
    disable iff (!rst_s_n) in_nmi_reg && nmi_request ##2 in_nmi_reg &&
    nmi_request && !irq_return_instr |=> nmi_pend_reg && in_nmi_reg)
    else $error("repeated nmi lost");

  a_edge_top_zero: assert property (@(posedge clk) // R6
    disable iff (!rst_s_n) sfr_rd && (sfr_addr == `ADDR_RISE_EN ||
    sfr_addr == `ADDR_FALL_EN) |=> sfr_rdata[7:6] == 2'h0)
    else $error("edge top bits set");

endmodule

// ### rtl/irq_consts.svh
`ifndef IRQ_CONSTS_SVH
`define IRQ_CONSTS_SVH

// special function register addresses
`define ADDR_PRIO_LOW0 16'hffe8
`define ADDR_PRIO_HIGH0 16'hffe9
`define ADDR_PRIO_LOW1 16'hffea
`define ADDR_RISE_EN 16'hff48
`define ADDR_FALL_EN 16'hff49

// reset values
`define PRIO_RESET 8'hff
`define EDGE_RESET 8'h00
`define PSW_RESET 8'h02

// status word field positions
`define PSW_IE_BIT 7
`define PSW_ISP_BIT 1

// edge enable registers hold six pins
`define EDGE_PINS 6

// request to servicing latency, in cpu clocks
`define LAT_HIGH_MIN 7
`define LAT_HIGH_MAX 32
`define LAT_LOW_MIN 8
`define LAT_LOW_MAX 33

`endif

// ### rtl/irq_pkg.sv
package irq_pkg;

  // acknowledge sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_LOW_WAIT = 5'h02,
    ST_PUSH_PSW = 5'h04,
    ST_PUSH_PC = 5'h08,
    ST_VECTOR = 5'h10
  } ack_state_t;

  // trigger selection, {rising, falling}
  typedef enum logic [1:0] {
    TRIG_OFF = 2'h0,
    TRIG_FALL = 2'h1,
    TRIG_RISE = 2'h2,
    TRIG_BOTH = 2'h3
  } trig_t;

endpackage

// ### rtl/irq_sel_if.sv
`timescale 1ns/1ps
interface irq_sel_if #(
  parameter int N = 22,
  parameter int IDX_W = 5
);
  logic [N-1:0] eligible;
  logic [N-1:0] level;
  logic found;
  logic [IDX_W-1:0] pick;
  logic pick_level;

  modport req (output eligible, output level, input found, input pick,
               input pick_level);
  modport sel (input eligible, input level, output found, output pick,
               output pick_level);
endinterface

// ### rtl/edge_detect.sv
`timescale 1ns/1ps
module edge_detect #(
  parameter int PINS = 6
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [PINS-1:0] pin_in,
  input wire logic [PINS-1:0] rise_en,
  input wire logic [PINS-1:0] fall_en,
  output logic [PINS-1:0] edge_pulse
);

  // per pin: two-flop synchroniser, history, trigger decode
  genvar g;
  generate
    for (g = 0; g < PINS; g++) begin : g_pin
      logic sync1_reg;
      logic sync2_reg;
      logic prev_reg;
      irq_pkg::trig_t trig;

      assign trig = irq_pkg::trig_t'({rise_en[g], fall_en[g]});

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          sync1_reg <= 1'b0;
          sync2_reg <= 1'b0;
          prev_reg <= 1'b0;
        end else begin
          sync1_reg <= pin_in[g];
          sync2_reg <= sync1_reg;
          prev_reg <= sync2_reg;
        end
      end

      // selected edges become a one-cycle pulse
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          edge_pulse[g] <= 1'b0;
        end else begin
          case (trig)
            irq_pkg::TRIG_OFF: edge_pulse[g] <= 1'b0;
            irq_pkg::TRIG_FALL: edge_pulse[g] <= prev_reg & ~sync2_reg;
            irq_pkg::TRIG_RISE: edge_pulse[g] <= ~prev_reg & sync2_reg;
            irq_pkg::TRIG_BOTH: edge_pulse[g] <= prev_reg ^ sync2_reg;
            default: edge_pulse[g] <= 1'b0;
          endcase
        end
      end
    end
  endgenerate

endmodule

// ### rtl/priority_select.sv
`timescale 1ns/1ps
module priority_select #(
  parameter int N = 22,
  parameter int IDX_W = 5
) (
  irq_sel_if.sel sel
);

  // higher level first, then lowest index (fixed default order)
  always_comb begin
    logic hi_any;
    hi_any = |(sel.eligible & ~sel.level);
    sel.found = 1'b0;
    sel.pick = '0;
    sel.pick_level = 1'b1;
    for (int i = N - 1; i >= 0; i--) begin
      if (sel.eligible[i] && (!hi_any || !sel.level[i])) begin
        sel.found = 1'b1;
        sel.pick = IDX_W'(i);
        sel.pick_level = sel.level[i];
      end
    end
  end

endmodule

// ### tb/irq_partner_model.sv
`timescale 1ns/1ps
// far side: peripheral request flags, masks and cpu instruction ends
module irq_partner_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [21:0] req_set,
  input wire logic [21:0] mask_val,
  input wire logic slow,
  input wire logic hold,
  input wire logic busy,
  input wire logic [21:0] request_clear,
  output logic [21:0] request_flag,
  output logic [21:0] mask_flag,
  output logic instr_end,
  output logic instr_hold
);
  logic [1:0] cnt_reg;

  // flags raised by peripherals, dropped when acknowledged; raise wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      request_flag <= '0;
    end else begin
      request_flag <= (request_flag & ~request_clear) | req_set;
    end
  end

  // slow mode ends an instruction every fourth cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 2'h0;
    end else begin
      cnt_reg <= cnt_reg + 2'h1;
    end
  end

  // no instruction completes while the acknowledge sequence runs
  assign instr_end = !busy && (!slow || cnt_reg == 2'h3);
  assign instr_hold = hold && instr_end;
  assign mask_flag = mask_val;
endmodule

// ### tb/interrupt_priority_acknowledge_tb_top.sv
`timescale 1ns/1ps
`include "irq_consts.svh"
module interrupt_priority_acknowledge_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] sfr_addr = '0, sfr_wdata = '0, sfr_rdata;
  logic sfr_wr_byte = 1'b0, sfr_wr_word = 1'b0, sfr_bit_wr = 1'b0;
  logic sfr_rd = 1'b0, nmi_request = 1'b0, slow = 1'b0, hold = 1'b0;
  logic [2:0] sfr_bit_pos = '0;
  logic [5:0] pins = '0, ext_edge_event;
  logic [21:0] request_flag, mask_flag, request_clear, e;
  logic [21:0] req_set = '0, mask_val = '1;
  logic enable_irq_instr = 1'b0, disable_irq_instr = 1'b0;
  logic psw_write = 1'b0, psw_restore = 1'b0, irq_return_instr = 1'b0;
  logic [7:0] psw_wdata = '0, psw_restore_data = '0;
  logic [7:0] status_word, stack_data, st_exp;
  logic instr_end, instr_hold, ack_busy, push_psw, push_pc, vector_load;
  logic vector_nmi, rd_d, vl_d;
  logic [4:0] vector_index;
  logic [31:0] rd_q[$], rnd, e32;
  logic [21:0] ack_q[$];
  int n_fail = 0, compares = 0, l0, l1, cnt, k, m;

  interrupt_priority_acknowledge i_interrupt_priority_acknowledge (
    .clk, .rst_n, .sfr_addr, .sfr_wdata, .sfr_wr_byte, .sfr_wr_word,
    .sfr_bit_wr, .sfr_bit_pos, .sfr_rd, .sfr_rdata,
    .external_irq_pin(pins), .ext_edge_event, .request_flag, .mask_flag,
    .request_clear, .nmi_request, .instr_end, .instr_hold,
    .enable_irq_instr, .disable_irq_instr, .psw_write, .psw_wdata,
    .psw_restore, .psw_restore_data, .irq_return_instr, .status_word,
    .ack_busy, .push_psw, .push_pc, .vector_load, .stack_data,
    .vector_nmi, .vector_index
  );

  irq_partner_model i_irq_partner_model (
    .clk, .rst_n, .req_set, .mask_val, .slow, .hold, .busy(ack_busy),
    .request_clear, .request_flag, .mask_flag, .instr_end, .instr_hold
  );

  // free running cpu clock
  initial begin
    forever #5 clk = ~clk;
  end

  task automatic final_report;
    if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(logic [15:0] got, logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(int n = 1);
    repeat (n) @(negedge clk);
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick();
    s = 1'b0;
    tick();
  endtask

  task automatic wr(logic [15:0] a, logic [15:0] d, logic w);
    sfr_addr = a;
    sfr_wdata = d;
    if (w) pulse(sfr_wr_word);
    else pulse(sfr_wr_byte);
  endtask

  task automatic rd(logic [15:0] a, logic [15:0] x, logic [15:0] msk);
    sfr_addr = a;
    rd_q.push_back({msk, x});
    pulse(sfr_rd);
  endtask

  task automatic setpsw(logic [7:0] d, logic restore);
    psw_wdata = d;
    psw_restore_data = d;
    if (restore) pulse(psw_restore);
    else pulse(psw_write);
  endtask

  // expected {nmi, index, stacked status, status after acceptance}
  function automatic logic [21:0] mk(logic nm, logic [4:0] ix,
                                     logic [7:0] p, logic lv);
    return {nm, ix, p, 1'b0, p[6:2], lv, p[0]};
  endfunction

  task automatic raise(logic [21:0] s);
    req_set = s;
    tick();
    req_set = '0;
  endtask

  task automatic wait_ack(output int n);
    for (n = 0; n < 60 && push_psw !== 1'b1; n++) tick();
    if (n == 60) begin
      n_fail++;
      $display("MISMATCH %0t no acknowledge", $time);
      final_report();
    end
    for (int i = 0; i < 9 && ack_busy === 1'b1; i++) tick();
    tick(2);
  endtask

  task automatic pair(logic [21:0] s, logic [4:0] a, logic la,
                      logic [4:0] b, logic lb);
    setpsw(8'h82, 1'b0);
    ack_q.push_back(mk(1'b0, a, 8'h82, la));
    ack_q.push_back(mk(1'b0, b, 8'h82, lb));
    raise(s);
    wait_ack(l0);
    setpsw(8'h82, 1'b1);
    wait_ack(l0);
  endtask

  task automatic ret_nmi;
    psw_restore_data = 8'h82;
    psw_restore = 1'b1;
    irq_return_instr = 1'b1;
    tick();
    psw_restore = 1'b0;
    irq_return_instr = 1'b0;
    tick();
  endtask

  // watcher: read data and acknowledge contents against the notes
  always @(posedge clk) begin
    rd_d <= sfr_rd;
    vl_d <= vector_load;
  end
  always @(negedge clk) begin
    if (rd_d === 1'b1) begin
      e32 = rd_q.pop_front();
      chk(sfr_rdata & e32[31:16], e32[15:0]);
    end
    if (push_psw === 1'b1) begin
      if (ack_q.size() == 0) chk(16'hdead, 16'h0);
      else begin
        e = ack_q.pop_front();
        st_exp = e[7:0];
        chk({2'h0, vector_nmi, e[21] ? 5'h0 : vector_index, stack_data},
            {2'h0, e[21:8]});
      end
    end
    if (vl_d === 1'b1) chk({8'h0, status_word}, {8'h0, st_exp});
  end

  // hang guard
  initial begin
    repeat (30000) @(posedge clk);
    n_fail++;
    $display("MISMATCH %0t run limit reached", $time);
    final_report();
  end

  // main sequence
  initial begin
    void'($urandom(32'h3468a47c));
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    tick(4);
    chk({8'h0, status_word}, 16'h0002);
    rd(16'hffe8, 16'hffff, 16'hffff);
    rd(16'hffea, 16'h00ff, 16'h00ff);
    rd(16'hff48, 16'h0000, 16'h00ff);
    rd(16'hff49, 16'h0000, 16'h00ff);
    rd(16'h0123, 16'h0000, 16'hffff);
    // edge enables: unused bits read zero, then every trigger mode
    rnd = $urandom;
    wr(16'hff48, {8'h0, rnd[7:0] | 8'hc0}, 1'b0);
    wr(16'hff49, {8'h0, rnd[15:8] | 8'hc0}, 1'b0);
    rd(16'hff48, {10'h0, rnd[5:0]}, 16'h00ff);
    rd(16'hff49, {10'h0, rnd[13:8]}, 16'h00ff);
    for (m = 0; m < 4; m++) begin
      wr(16'hff48, {10'h0, {6{m[1]}}}, 1'b0);
      wr(16'hff49, {10'h0, {6{m[0]}}}, 1'b0);
      cnt = 0;
      for (int p = 0; p < 2; p++) begin
        pins = (p == 0) ? 6'h3f : 6'h00;
        repeat (8) begin
          tick();
          cnt += $countones(ext_edge_event);
        end
      end
      chk(16'(cnt), 16'(6 * (m[1] + m[0])));
    end
    // priority bytes: word, byte and bit access
    rnd = $urandom | 32'h1;
    wr(16'hffe8, rnd[15:0], 1'b1);
    rd(16'hffe8, rnd[15:0], 16'hffff);
    wr(16'hffe9, 16'h00a5, 1'b0);
    rd(16'hffe8, {8'ha5, rnd[7:0]}, 16'hffff);
    sfr_addr = 16'hffe8;
    sfr_bit_pos = 3'h4;
    sfr_wdata = 16'h0;
    pulse(sfr_bit_wr);
    rd(16'hffe8, {8'ha5, rnd[7:5], 1'b0, rnd[3:0]}, 16'hffff);
    wr(16'hffe8, 16'hf9f7, 1'b1);
    wr(16'hffea, 16'h00ff, 1'b0);
    // status word controls
    pulse(enable_irq_instr);
    chk({8'h0, status_word}, 16'h0082);
    pulse(disable_irq_instr);
    chk({8'h0, status_word}, 16'h0002);
    setpsw(8'h80, 1'b0);
    chk({8'h0, status_word}, 16'h0080);
    setpsw(8'h02, 1'b1);
    chk({8'h0, status_word}, 16'h0002);
    // maskable acceptance at both levels
    mask_val = ~22'h00061c;
    setpsw(8'h82, 1'b0);
    ack_q.push_back(mk(1'b0, 5'd3, 8'h82, 1'b0));
    raise(22'h8);
    wait_ack(l0);
    chk(request_flag[15:0], 16'h0000);
    setpsw(8'h82, 1'b1);
    ack_q.push_back(mk(1'b0, 5'd2, 8'h82, 1'b1));
    raise(22'h4);
    wait_ack(l1);
    chk(16'(l1), 16'(l0 + 1));
    chk(16'(l0 <= `LAT_HIGH_MAX), 16'h1);
    // held off by disable, mask, priority, hold; then taken
    for (k = 0; k < 4; k++) begin
      slow = k[0];
      setpsw((k == 0) ? 8'h02 : (k == 2) ? 8'h80 : 8'h82, 1'b0);
      mask_val[2] = (k == 1);
      hold = (k == 3);
      if (k == 2) ack_q.push_back(mk(1'b0, 5'd3, 8'h80, 1'b0));
      raise((k == 2) ? 22'h00000c : 22'h000004);
      tick(20);
      ack_q.push_back(mk(1'b0, 5'd2, 8'h82, 1'b1));
      setpsw(8'h82, 1'b0);
      mask_val[2] = 1'b0;
      hold = 1'b0;
      wait_ack(l1);
    end
    slow = 1'b0;
    pair(22'h000404, 5'd10, 1'b0, 5'd2, 1'b1);
    pair(22'h000208, 5'd3, 1'b0, 5'd9, 1'b0);
    // non-maskable: outranks, no nesting, repeats collapse
    setpsw(8'h82, 1'b0);
    ack_q.push_back(mk(1'b1, 5'd0, 8'h82, 1'b0));
    nmi_request = 1'b1;
    raise(22'h8);
    nmi_request = 1'b0;
    wait_ack(l0);
    setpsw(8'h82, 1'b0);
    pulse(nmi_request);
    pulse(nmi_request);
    tick(15);
    ack_q.push_back(mk(1'b1, 5'd0, 8'h82, 1'b0));
    ret_nmi();
    wait_ack(l0);
    ack_q.push_back(mk(1'b0, 5'd3, 8'h82, 1'b0));
    ret_nmi();
    wait_ack(l0);
    tick(15);
    chk(16'(ack_q.size()), 16'h0);
    final_report();
  end
endmodule
